/* src/tcs_burst.sv */
// Indicator burst generator: one or two low pulses each period. A change of
// request restarts the period and starts a fresh burst on the next cycle.
`timescale 1ns/1ps
`default_nettype none
module tcs_burst #(
	parameter int unsigned MINUTE_CYC = tcs_pkg::PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	tcs_link_if.burst_mp lk_io
);
	import tcs_pkg::*;

	localparam logic [31:0] LAST = 32'(MINUTE_CYC - 1);

	tcs_burst_t state_reg;
	tcs_burst_t state_next;
	logic [1:0] req_reg;
	logic [31:0] per_reg;
	logic [11:0] wid_reg;
	logic low_reg;
	logic [11:0] low_len;
	logic change;
	logic expire;
	logic wid_end;

	assign change = lk_io.burst_req != req_reg;
	assign expire = per_reg == LAST;
	assign wid_end = wid_reg == PULSE_LEN - 12'h001;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_reg <= 32'h0;
			req_reg <= BURST_NONE;
		end else begin
			req_reg <= lk_io.burst_req;
			if (change || expire) begin
				per_reg <= change ? LAST : 32'h0;
			end else begin
				per_reg <= per_reg + 32'h1;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BU_IDLE: begin
				if (expire && req_reg != BURST_NONE) begin
					state_next = BU_LOW1;
				end
			end
			BU_LOW1: begin
				if (wid_end) begin
					state_next = (req_reg == BURST_TWO) ? BU_GAP : BU_IDLE;
				end
			end
			BU_GAP: begin
				if (wid_end) begin
					state_next = BU_LOW2;
				end
			end
			BU_LOW2: begin
				if (wid_end) begin
					state_next = BU_IDLE;
				end
			end
			default: begin
				state_next = BU_IDLE;
			end
		endcase
		if (change) begin
			state_next = BU_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= BU_IDLE;
			wid_reg <= 12'h0;
			low_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wid_reg <= (state_next != state_reg) ? 12'h0 : wid_reg + 12'h1;
			low_reg <= state_next == BU_LOW1 || state_next == BU_LOW2;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_len <= 12'h0;
		end else begin
			low_len <= low_reg ? low_len + 12'h1 : 12'h0;
		end
	end

	assign lk_io.burst_low = low_reg;

	chk_pulse_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(low_reg) && !$past(change) |-> low_len == PULSE_LEN)
		else $error("indicator pulse width wrong");

endmodule
`default_nettype wire

/* src/tcs_core.sv */
// Charger temperature and status core: thermistor regions, die thermal
// shutdown, open-drain power-good and interrupt pins, APB registers.
// Assumes comparator bits arrive asynchronously and the charger core
// signals (start-up, charging, faults, host mode) share clock_i.
`timescale 1ns/1ps
`default_nettype none
module tcs_core #(
	parameter int unsigned MINUTE_CYC = tcs_pkg::PERIOD_CYC
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic colder_than_cold_i,
	input wire logic cooler_than_cool_i,
	input wire logic warmer_than_warm_i,
	input wire logic hotter_than_hot_i,
	input wire logic ts_above_thermistor_disable_level_i,
	input wire logic die_above_shutdown_i,
	input wire logic die_below_hysteresis_i,
	input wire logic vin_above_input_lockout_level_i,
	input wire logic vin_below_input_sleep_level_i,
	input wire logic vin_below_input_droop_limit_level_i,
	input wire logic vin_above_bat_margin_i,
	input wire logic vin_below_ovp_i,
	input wire logic push_button_input_n_i,
	input wire logic startup_done_i,
	input wire logic startup_fault_i,
	input wire logic charging_i,
	input wire logic fault_event_i,
	input wire logic host_mode_i,
	output logic charge_enable_o,
	output logic charge_timers_pause_o,
	output logic half_current_o,
	output logic [7:0] vreg_offset_mv_o,
	output logic mid_rail_output_en_o,
	output logic sys_output_en_o,
	output logic aux_switch_regulator_output_en_o,
	output logic safety_timer_clear_o,
	output logic watchdog_run_o,
	output logic charge_restart_o,
	output logic power_good_output_o,
	output logic power_good_output_oe_o,
	output logic int_o,
	output logic int_oe_o
);
	import tcs_pkg::*;

	logic rst_sync1;
	logic rst_n;
	logic [SYNC_N-1:0] async_vec;
	logic [SYNC_N-1:0] sync1;
	logic [SYNC_N-1:0] s;
	logic valid_reg;
	logic start_fault_reg;
	tcs_therm_t therm_reg;
	tcs_therm_t therm_next;
	logic [3:0] ctrl_reg;
	logic [11:0] fault_cnt;
	logic [1:0] burst_req;
	logic pg_oe_next;
	logic int_oe_next;
	logic access;
	logic hit_ctrl;
	logic hit_stat;
	logic [31:0] status_word;

	tcs_link_if lk ();

	// Reset is released through two flops so all logic leaves reset together
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_n <= rst_sync1;
		end
	end

	assign async_vec = {
		push_button_input_n_i,
		vin_below_ovp_i,
		vin_above_bat_margin_i,
		vin_below_input_droop_limit_level_i,
		vin_below_input_sleep_level_i,
		vin_above_input_lockout_level_i,
		die_below_hysteresis_i,
		die_above_shutdown_i,
		ts_above_thermistor_disable_level_i,
		hotter_than_hot_i,
		warmer_than_warm_i,
		cooler_than_cool_i,
		colder_than_cold_i
	};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			always_ff @(posedge clock_i or negedge rst_n) begin
				if (!rst_n) begin
					sync1[gi] <= SYNC_RST[gi];
					s[gi] <= SYNC_RST[gi];
				end else begin
					sync1[gi] <= async_vec[gi];
					s[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	assign lk.cold = s[IN_COLD];
	assign lk.cool = s[IN_COOL];
	assign lk.warm = s[IN_WARM];
	assign lk.hot = s[IN_HOT];
	assign lk.ts_off = s[IN_THERMISTOR_DISABLE_LEVEL];
	assign lk.burst_req = burst_req;

	tcs_region u_region (
		.clk_i(clock_i),
		.rst_n_i(rst_n),
		.lk_io(lk.region_mp)
	);

	tcs_burst #(
		.MINUTE_CYC(MINUTE_CYC)
	) u_burst (
		.clk_i(clock_i),
		.rst_n_i(rst_n),
		.lk_io(lk.burst_mp)
	);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			valid_reg <= 1'b0;
			start_fault_reg <= 1'b0;
		end else if (startup_done_i && !valid_reg && !start_fault_reg) begin
			valid_reg <= !startup_fault_i;
			start_fault_reg <= startup_fault_i;
		end
	end

	always_comb begin
		therm_next = therm_reg;
		case (therm_reg)
			TH_RUN: begin
				if (s[IN_DIE_HOT]) begin
					therm_next = TH_SHUT;
				end
			end
			TH_SHUT: begin
				if (s[IN_DIE_OK] && !s[IN_DIE_HOT]) begin
					therm_next = TH_RUN;
				end
			end
			default: begin
				therm_next = TH_RUN;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			therm_reg <= TH_RUN;
			charge_restart_o <= 1'b0;
		end else begin
			therm_reg <= therm_next;
			charge_restart_o <= therm_reg == TH_SHUT && therm_next == TH_RUN;
		end
	end

	// die overheat kills charge and rails
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			charge_enable_o <= 1'b0;
			mid_rail_output_en_o <= 1'b1;
			sys_output_en_o <= 1'b1;
			aux_switch_regulator_output_en_o <= 1'b1;
		end else begin
			charge_enable_o <= therm_reg == TH_RUN && lk.region != RG_SUSPEND;
			mid_rail_output_en_o <= therm_reg == TH_RUN;
			sys_output_en_o <= therm_reg == TH_RUN;
			aux_switch_regulator_output_en_o <= therm_reg == TH_RUN;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			safety_timer_clear_o <= 1'b0;
			watchdog_run_o <= 1'b0;
		end else begin
			safety_timer_clear_o <= therm_reg == TH_SHUT;
			watchdog_run_o <= host_mode_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			charge_timers_pause_o <= 1'b0;
			half_current_o <= 1'b0;
			vreg_offset_mv_o <= 8'h00;
		end else begin
			charge_timers_pause_o <= lk.region == RG_SUSPEND;
			half_current_o <= lk.region == RG_COOL;
			vreg_offset_mv_o <= (lk.region == RG_WARM) ? VREG_DROP_MV : 8'h00;
		end
	end

	always_comb begin
		burst_req = BURST_NONE;
		if (ctrl_reg[CTRL_VIND]) begin
			if (s[IN_SLEEP] || (ctrl_reg[CTRL_DPM] && s[IN_DROOP])) begin
				burst_req = BURST_ONE;
			end else if (s[IN_ABOVE_BAT] && s[IN_BELOW_OVP]) begin
				burst_req = BURST_TWO;
			end
		end
	end

	always_comb begin
		pg_oe_next = 1'b0;
		if (!valid_reg) begin
			pg_oe_next = 1'b0;
		end else if (ctrl_reg[CTRL_MIRROR]) begin
			pg_oe_next = !s[IN_BUTTON_N];
		end else if (ctrl_reg[CTRL_VIND]) begin
			pg_oe_next = lk.burst_low;
		end else begin
			pg_oe_next = s[IN_UVLO];
		end
	end

	// one fault pulse; a new fault restarts it
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			fault_cnt <= 12'h0;
		end else if (fault_event_i && valid_reg) begin
			fault_cnt <= PULSE_LEN;
		end else if (fault_cnt != 12'h0) begin
			fault_cnt <= fault_cnt - 12'h1;
		end
	end

	assign int_oe_next = valid_reg &&
		((ctrl_reg[CTRL_INT_EN] && charging_i) || fault_cnt != 12'h0);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			power_good_output_oe_o <= 1'b0;
			int_oe_o <= 1'b0;
			power_good_output_o <= 1'b0;
			int_o <= 1'b0;
		end else begin
			power_good_output_oe_o <= pg_oe_next;
			int_oe_o <= int_oe_next;
			power_good_output_o <= 1'b0;
			int_o <= 1'b0;
		end
	end

	// APB slave: one wait state, answer from flops
	assign access = psel_i && penable_i && pready_o;
	assign hit_ctrl = paddr_i == CTRL_OFS;
	assign hit_stat = paddr_i == STATUS_OFS;
	assign status_word = {20'h0, int_oe_o, power_good_output_oe_o,
		start_fault_reg, valid_reg, therm_reg == TH_SHUT, charging_i,
		lk.region, ctrl_reg};

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end else if (psel_i && penable_i && !pready_o) begin
			pready_o <= 1'b1;
			pslverr_o <= !(hit_ctrl || hit_stat);
			if (pwrite_i) begin
				prdata_o <= 32'h0;
			end else if (hit_ctrl) begin
				prdata_o <= {28'h0, ctrl_reg};
			end else if (hit_stat) begin
				prdata_o <= status_word;
			end else begin
				prdata_o <= 32'h0;
			end
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RST;
		end else if (access && pwrite_i && hit_ctrl) begin
			ctrl_reg <= pwdata_i[3:0];
		end
	end

	chk_shut_rails_off: assert property (@(posedge clock_i) disable iff (!rst_n)
		therm_reg == TH_SHUT |=> !charge_enable_o && !mid_rail_output_en_o
		&& !sys_output_en_o && !aux_switch_regulator_output_en_o)
		else $error("rails or charge on during die shutdown");

	chk_safety_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
		therm_reg == TH_SHUT |=> safety_timer_clear_o
		&& watchdog_run_o == $past(host_mode_i))
		else $error("safety timer not held or watchdog stopped");

	chk_shut_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
		therm_reg == TH_SHUT && !s[IN_DIE_OK] ##1 !charge_restart_o
		|-> therm_reg == TH_SHUT)
		else $error("charge resumed above hysteresis point");

	chk_invalid_quiet: assert property (@(posedge clock_i) disable iff (!rst_n)
		!valid_reg |=> !int_oe_o && !power_good_output_oe_o)
		else $error("status pins active before valid start-up");

	chk_pg_default: assert property (@(posedge clock_i) disable iff (!rst_n)
		valid_reg && !ctrl_reg[CTRL_MIRROR] && !ctrl_reg[CTRL_VIND]
		|=> power_good_output_oe_o == $past(s[IN_UVLO]))
		else $error("power good does not follow lockout");

	chk_pg_mirror: assert property (@(posedge clock_i) disable iff (!rst_n)
		valid_reg && ctrl_reg[CTRL_MIRROR]
		|=> power_good_output_oe_o == !$past(s[IN_BUTTON_N]))
		else $error("power good does not mirror button");

	chk_int_charging: assert property (@(posedge clock_i) disable iff (!rst_n)
		valid_reg && ctrl_reg[CTRL_INT_EN] && charging_i |=> int_oe_o && !int_o)
		else $error("interrupt not low while charging");

	chk_int_disabled: assert property (@(posedge clock_i) disable iff (!rst_n)
		!ctrl_reg[CTRL_INT_EN] && fault_cnt == 12'h0 && !fault_event_i
		|=> !int_oe_o)
		else $error("charging shown with interrupt disabled");

	chk_fault_pulse: assert property (@(posedge clock_i) disable iff (!rst_n)
		valid_reg && fault_event_i ##1 !fault_event_i[*2]
		|-> fault_cnt == PULSE_LEN - 12'h1 && int_oe_o)
		else $error("fault pulse not started");

endmodule
`default_nettype wire

/* src/tcs_link_if.sv */
// Signals shared between the status core, the region decoder and the
// indicator burst generator. All on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface tcs_link_if;
	logic cold;
	logic cool;
	logic warm;
	logic hot;
	logic ts_off;
	tcs_pkg::tcs_region_t region;
	logic [1:0] burst_req;
	logic burst_low;
	modport region_mp(input cold, cool, warm, hot, ts_off, output region);
	modport burst_mp(input burst_req, output burst_low);
	modport core_mp(output cold, cool, warm, hot, ts_off, burst_req,
		input region, burst_low);
endinterface
`default_nettype wire

/* src/tcs_pkg.sv */
// Constants, field layout and state types of the charger temperature and
// status logic. Assumes a 25 MHz core clock.
// Summary of operation
// - Hot or cold battery: suspend charge, pause timers
// - Cool region: halve the fast-charge current target
// - Warm region: lower regulation voltage by 140 mV
// - Thermistor disabled: treat battery as normal temperature
// - Die overheat: stop charge, mid, system, aux outputs
// - Die overheat: clear safety timer, watchdog keeps running
// - Restart charge only below shutdown minus hysteresis
// - Status outputs idle until valid start-up
// - Default: power good low above lockout level
// - Mirror select: power good follows push button
// - Indicator: one pulse per minute when input low
// - Indicator: two pulses per minute when input high
// - Indicator mode: power good not a steady level
// - Interrupt enabled: interrupt low while charging
// - Interrupt disabled: no charging status shown
// - Charge done or disabled: interrupt released
// - Each fault: one 128 us interrupt pulse
// - Same status for first charge and recharge
`default_nettype none
package tcs_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned PULSE_US = 128;
	localparam int unsigned PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PERIOD_S = 60;
	localparam int unsigned PERIOD_CYC = PERIOD_S * CLK_HZ;
	localparam int PULSE_W = 12;
	localparam logic [11:0] PULSE_LEN = 12'(PULSE_CYC);
	localparam logic [7:0] VREG_DROP_MV = 8'h8c;

	// Register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int CTRL_INT_EN = 0;
	localparam int CTRL_MIRROR = 1;
	localparam int CTRL_VIND = 2;
	localparam int CTRL_DPM = 3;
	localparam logic [3:0] CTRL_RST = 4'h1;

	// Indicator burst requests
	localparam logic [1:0] BURST_NONE = 2'h0;
	localparam logic [1:0] BURST_ONE = 2'h1;
	localparam logic [1:0] BURST_TWO = 2'h2;

	// Synchroniser bit positions
	localparam int IN_COLD = 0;
	localparam int IN_COOL = 1;
	localparam int IN_WARM = 2;
	localparam int IN_HOT = 3;
	localparam int IN_THERMISTOR_DISABLE_LEVEL = 4;
	localparam int IN_DIE_HOT = 5;
	localparam int IN_DIE_OK = 6;
	localparam int IN_UVLO = 7;
	localparam int IN_SLEEP = 8;
	localparam int IN_DROOP = 9;
	localparam int IN_ABOVE_BAT = 10;
	localparam int IN_BELOW_OVP = 11;
	localparam int IN_BUTTON_N = 12;
	localparam int SYNC_N = 13;
	localparam logic [12:0] SYNC_RST = 13'h1000;

	typedef enum logic [1:0] {
		RG_NORMAL = 2'h0,
		RG_COOL = 2'h1,
		RG_WARM = 2'h3,
		RG_SUSPEND = 2'h2
	} tcs_region_t;

	typedef enum logic [1:0] {
		BU_IDLE = 2'h0,
		BU_LOW1 = 2'h1,
		BU_GAP = 2'h3,
		BU_LOW2 = 2'h2
	} tcs_burst_t;

	typedef enum logic {
		TH_RUN = 1'h0,
		TH_SHUT = 1'h1
	} tcs_therm_t;

endpackage
`default_nettype wire

/* src/tcs_region.sv */
// Battery temperature region decoder. Expects comparator bits that are
// already synchronised to the core clock.
`timescale 1ns/1ps
`default_nettype none
module tcs_region (
	input wire logic clk_i,
	input wire logic rst_n_i,
	tcs_link_if.region_mp lk_io
);
	import tcs_pkg::*;

	tcs_region_t region_reg;
	tcs_region_t region_next;

	always_comb begin
		region_next = RG_NORMAL;
		if (lk_io.ts_off) begin
			region_next = RG_NORMAL;
		end else if (lk_io.hot || lk_io.cold) begin
			region_next = RG_SUSPEND;
		end else if (lk_io.cool) begin
			region_next = RG_COOL;
		end else if (lk_io.warm) begin
			region_next = RG_WARM;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			region_reg <= RG_NORMAL;
		end else begin
			region_reg <= region_next;
		end
	end

	assign lk_io.region = region_reg;

	chk_off_is_normal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		lk_io.ts_off |=> region_reg == RG_NORMAL)
		else $error("disabled thermistor did not read normal");

	chk_hot_suspends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!lk_io.ts_off && (lk_io.hot || lk_io.cold) |=> region_reg == RG_SUSPEND)
		else $error("hot or cold battery did not suspend");

	chk_cool_halves: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!lk_io.ts_off && !lk_io.hot && !lk_io.cold && lk_io.cool
		|=> region_reg == RG_COOL)
		else $error("cool battery not in cool region");

endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the temperature and status core.
// Assumes APB on the core clock and a shortened indicator period.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tcs_pkg::*;
	localparam int unsigned MIN_CYC = 20000;
	localparam int unsigned PW = PULSE_CYC;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	logic cold, cool, warm, hot, thermistor_disable_level, die_hot, die_ok, lockout, sleep;
	logic droop, above_bat, below_ovp, button_n, st_done, st_fault;
	logic charging, fault_ev, host_mode;
	logic ce, pause, half, mid_en, sys_en, aux_en, st_clr, wd_run, restart;
	logic [7:0] voff;
	logic pg, pg_oe, intr, int_oe, pg_line, int_line;
	int pg_lows, pg_width, int_lows, int_width;
	int n_fail = 0;
	int check_count = 0;
	logic [4:0] reg_case [9] = '{5'h00, 5'h08, 5'h01, 5'h03, 5'h02, 5'h04,
		5'h0c, 5'h18, 5'h12};

	always #20 clk = ~clk;

	tcs_core #(.MINUTE_CYC(MIN_CYC)) i_tcs_core (.clock_i(clk),
		.arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.colder_than_cold_i(cold), .cooler_than_cool_i(cool),
		.warmer_than_warm_i(warm), .hotter_than_hot_i(hot),
		.ts_above_thermistor_disable_level_i(thermistor_disable_level),
		.die_above_shutdown_i(die_hot), .die_below_hysteresis_i(die_ok),
		.vin_above_input_lockout_level_i(lockout),
		.vin_below_input_sleep_level_i(sleep),
		.vin_below_input_droop_limit_level_i(droop),
		.vin_above_bat_margin_i(above_bat), .vin_below_ovp_i(below_ovp),
		.push_button_input_n_i(button_n), .startup_done_i(st_done),
		.startup_fault_i(st_fault), .charging_i(charging),
		.fault_event_i(fault_ev), .host_mode_i(host_mode),
		.charge_enable_o(ce), .charge_timers_pause_o(pause),
		.half_current_o(half), .vreg_offset_mv_o(voff),
		.mid_rail_output_en_o(mid_en), .sys_output_en_o(sys_en),
		.aux_switch_regulator_output_en_o(aux_en),
		.safety_timer_clear_o(st_clr), .watchdog_run_o(wd_run),
		.charge_restart_o(restart), .power_good_output_o(pg),
		.power_good_output_oe_o(pg_oe), .int_o(intr), .int_oe_o(int_oe));

	tcs_host_model i_tcs_host_model (.clk_i(clk), .pg_i(pg), .pg_oe_i(pg_oe),
		.int_i(intr), .int_oe_i(int_oe), .pg_line_o(pg_line),
		.int_line_o(int_line), .pg_lows_o(pg_lows), .pg_width_o(pg_width),
		.int_lows_o(int_lows), .int_width_o(int_width));

	task automatic final_report();
		$display("Checks made %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Holds the whole request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			final_report();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, CTRL_OFS, d, r, e);
	endtask

	// Hot and cold beat cool, cool beats warm, disable beats all
	function automatic logic [10:0] exp_reg(input logic [4:0] c);
		if (c[4]) return {3'b100, 8'h00};
		if (c[3] | c[0]) return {3'b010, 8'h00};
		if (c[1]) return {3'b101, 8'h00};
		if (c[2]) return {3'b100, VREG_DROP_MV};
		return {3'b100, 8'h00};
	endfunction

	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		final_report();
	end

	initial begin
		logic [31:0] d;
		logic e;
		int i, n, n0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cold, cool, warm, hot, thermistor_disable_level, die_hot, die_ok, sleep, droop} = '0;
		{above_bat, below_ovp, st_done, st_fault, charging} = '0;
		{fault_ev, host_mode} = '0;
		button_n = 1'b1;
		lockout = 1'b1;
		cyc(4);
		arst_n <= 1'b1;
		cyc(8);
		chk(pg_line, 1'b1);
		apb(1'b0, CTRL_OFS, '0, d, e);
		chk(d, 32'h1);
		apb(1'b0, 8'h08, '0, d, e);
		chk(d, 32'h0);
		chk(e, 1'b1);
		for (i = 0; i < 9; i++) begin
			@(posedge clk);
			{thermistor_disable_level, hot, warm, cool, cold} <= reg_case[i];
			cyc(6);
			chk({ce, pause, half, voff}, exp_reg(reg_case[i]));
		end
		@(posedge clk);
		host_mode <= 1'b1;
		die_hot <= 1'b1;
		cyc(6);
		chk({ce, mid_en, sys_en, aux_en}, 4'h0);
		chk({st_clr, wd_run}, 2'h3);
		@(posedge clk);
		die_hot <= 1'b0;
		cyc(6);
		chk({ce, mid_en}, 2'h0);
		@(posedge clk);
		die_ok <= 1'b1;
		n = 0;
		while (restart !== 1'b1 && n < 12) begin
			@(posedge clk);
			n++;
		end
		chk(n < 12, 1'b1);
		cyc(4);
		chk({ce, mid_en, sys_en, aux_en, st_clr}, 5'h1e);
		@(posedge clk);
		st_done <= 1'b1;
		host_mode <= 1'b0;
		cyc(6);
		chk(pg_line, 1'b0);
		chk(wd_run, 1'b0);
		@(posedge clk);
		lockout <= 1'b0;
		cyc(6);
		chk(pg_line, 1'b1);
		wr(32'h3);
		@(posedge clk);
		button_n <= 1'b0;
		cyc(6);
		chk(pg_line, 1'b0);
		@(posedge clk);
		button_n <= 1'b1;
		lockout <= 1'b1;
		cyc(6);
		chk(pg_line, 1'b1);
		wr(32'h1);
		@(posedge clk);
		charging <= 1'b1;
		cyc(6);
		chk(int_line, 1'b0);
		wr(32'h0);
		cyc(6);
		chk(int_line, 1'b1);
		wr(32'h1);
		@(posedge clk);
		charging <= 1'b0;
		cyc(6);
		chk(int_line, 1'b1);
		@(posedge clk);
		charging <= 1'b1;
		cyc(6);
		chk(int_line, 1'b0);
		@(posedge clk);
		charging <= 1'b0;
		// Let the charging low be counted before marking the fault pulse
		cyc(4);
		n0 = int_lows;
		fault_ev <= 1'b1;
		@(posedge clk);
		fault_ev <= 1'b0;
		cyc(PW + 20);
		chk(int_lows - n0, 1);
		chk(int_width, PW);
		wr(32'h5);
		cyc(6);
		chk(pg_line, 1'b1);
		apb(1'b0, STATUS_OFS, '0, d, e);
		chk(d, 32'h105);
		chk(e, 1'b0);
		n0 = pg_lows;
		sleep <= 1'b1;
		cyc(PW + 20);
		chk(pg_lows - n0, 1);
		chk(pg_width, PW);
		cyc(MIN_CYC - PW - 200);
		chk(pg_lows - n0, 1);
		cyc(PW + 300);
		chk(pg_lows - n0, 2);
		n0 = pg_lows;
		sleep <= 1'b0;
		above_bat <= 1'b1;
		below_ovp <= 1'b1;
		cyc(3 * PW + 40);
		chk(pg_lows - n0, 2);
		chk(pg_width, PW);
		// Droop level only counts once its enable bit is set
		wr(32'hd);
		n0 = pg_lows;
		droop <= 1'b1;
		cyc(PW + 40);
		chk(pg_lows - n0, 1);
		// A start-up that ends in a fault keeps both pins quiet
		arst_n <= 1'b0;
		st_fault <= 1'b1;
		cyc(4);
		arst_n <= 1'b1;
		cyc(8);
		n0 = int_lows;
		fault_ev <= 1'b1;
		@(posedge clk);
		fault_ev <= 1'b0;
		cyc(PW + 20);
		chk(int_lows - n0, 0);
		chk(pg_line, 1'b1);
		final_report();
	end
endmodule
`default_nettype wire

/* testbench/tcs_host_model.sv */
// Host side of the two open-drain status lines: pull-ups and pulse meters.
// Assumes out/oe pairs from the core and one shared clock.
`timescale 1ns/1ps
`default_nettype none
module tcs_host_model (
	input wire logic clk_i,
	input wire logic pg_i,
	input wire logic pg_oe_i,
	input wire logic int_i,
	input wire logic int_oe_i,
	output logic pg_line_o,
	output logic int_line_o,
	output int pg_lows_o,
	output int pg_width_o,
	output int int_lows_o,
	output int int_width_o
);
	int pg_run;
	int int_run;
	// A released line floats up through its pull-up, never holds its last value
	assign pg_line_o = pg_oe_i ? pg_i : 1'b1;
	assign int_line_o = int_oe_i ? int_i : 1'b1;
	// Counters are two-state and start at zero, so one process drives each
	// Widths are whole clock periods of low level seen at rising edges
	always @(posedge clk_i) begin
		if (pg_line_o !== 1'b1) begin
			pg_run <= pg_run + 1;
		end else if (pg_run > 0) begin
			pg_lows_o <= pg_lows_o + 1;
			pg_width_o <= pg_run;
			pg_run <= 0;
		end
		if (int_line_o !== 1'b1) begin
			int_run <= int_run + 1;
		end else if (int_run > 0) begin
			int_lows_o <= int_lows_o + 1;
			int_width_o <= int_run;
			int_run <= 0;
		end
	end
endmodule
`default_nettype wire
